// ### hdl/measurement_alarm_hold.sv
`timescale 1ns/1ps
module measurement_alarm_hold (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SAMPLE_STROBE,
    input wire alarm_hold_pkg::sample_s SAMPLE,
    input wire logic [alarm_hold_pkg::COUNT_W-1:0] HOLD_COUNT,
    input wire logic [alarm_hold_pkg::COUNT_W-1:0] RECOVERY_COUNT,
    input wire logic [alarm_hold_pkg::LEVEL_W-1:0] THRESHOLD_LEVEL,
    input wire logic MOUNT_SPECULAR,
    input wire logic HEAD_TRANSPARENT_TYPE,
    input wire logic HEAD_STATUS_IN,
    input wire logic LASER_EMIT_IN,
    input wire logic ADJUST_WRITE,
    input wire logic ADJUST_AUTO,
    input wire logic [alarm_hold_pkg::LIGHT_W-1:0] ADJUST_HI,
    input wire logic [alarm_hold_pkg::LIGHT_W-1:0] ADJUST_LO,
    input wire logic CAL_START,
    input wire logic CAL_STOP,
    input wire alarm_hold_pkg::cal_cond_s CAL_COND,
    output logic [alarm_hold_pkg::OUT_W-1:0] OUT_VALUE,
    output logic OUT_STROBE,
    output logic OUT_NO_VALUE,
    output logic ALARM,
    output logic HOLDING,
    output logic HEAD_STATUS_OUT,
    output logic LASER_EMIT_OUT,
    output logic SPECULAR_ACTIVE,
    output logic AUTO_LIGHT_LEVEL_ADJUST,
    output logic [alarm_hold_pkg::LIGHT_W-1:0] LIMIT_HI,
    output logic [alarm_hold_pkg::LIGHT_W-1:0] LIMIT_LO,
    output logic [alarm_hold_pkg::LIGHT_W-1:0] LIGHT_LEVEL_CMD,
    output logic CAL_BUSY,
    output logic CAL_DONE,
    output logic CAL_FAIL
);

    alarm_hold_pkg::hold_state_e state_reg;
    alarm_hold_pkg::hold_state_e state_next;
    alarm_hold_pkg::cal_state_e cal_reg;
    logic [alarm_hold_pkg::COUNT_W-1:0] hold_cnt_reg;
    logic [alarm_hold_pkg::COUNT_W-1:0] hold_cnt_next;
    logic [alarm_hold_pkg::COUNT_W-1:0] rec_cnt_reg;
    logic [alarm_hold_pkg::COUNT_W-1:0] rec_cnt_next;
    logic have_value_reg;
    logic [alarm_hold_pkg::OUT_W-1:0] value_reg;
    logic [alarm_hold_pkg::OUT_W-1:0] value_next;
    logic strobe_reg;
    logic no_value_reg;
    logic no_value_next;
    logic sample_valid;
    logic specular;
    logic signed [alarm_hold_pkg::OUT_W+9:0] product;
    logic [alarm_hold_pkg::OUT_W-1:0] corrected;
    logic auto_reg;
    logic [alarm_hold_pkg::LIGHT_W-1:0] hi_reg;
    logic [alarm_hold_pkg::LIGHT_W-1:0] lo_reg;
    logic [alarm_hold_pkg::LIGHT_W-1:0] max_reg;
    logic [alarm_hold_pkg::LIGHT_W-1:0] min_reg;
    logic seen_reg;
    logic [alarm_hold_pkg::LIGHT_W-1:0] cmd_reg;
    logic [alarm_hold_pkg::LIGHT_W-1:0] req_level;
    logic cal_done_reg;
    logic cal_blocked;
    logic group_input;

    // A higher threshold rejects more peaks, so level 0 never rejects.
    assign sample_valid = SAMPLE.in_range && !SAMPLE.light_excess
        && !SAMPLE.light_short
        && (SAMPLE.light_status >= THRESHOLD_LEVEL);

    assign specular = MOUNT_SPECULAR || HEAD_TRANSPARENT_TYPE;

    // The product is wide enough that no bits are lost before the shift.
    assign product = (alarm_hold_pkg::OUT_W + 10)'($signed(SAMPLE.value))
        * (alarm_hold_pkg::OUT_W + 10)'($signed({1'b0,
        alarm_hold_pkg::SPEC_NUM}));
    always_comb begin
        if (specular) begin
            corrected = alarm_hold_pkg::OUT_W'(
                product >>> alarm_hold_pkg::SPEC_SHIFT);
        end else begin
            corrected = alarm_hold_pkg::OUT_W'(SAMPLE.value);
        end
    end

    always_comb begin
        state_next = state_reg;
        hold_cnt_next = hold_cnt_reg;
        rec_cnt_next = rec_cnt_reg;
        value_next = value_reg;
        no_value_next = no_value_reg;
        if (SAMPLE_STROBE) begin
            case (state_reg)
                alarm_hold_pkg::ST_NORMAL: begin
                    if (sample_valid) begin
                        value_next = corrected;
                        no_value_next = 1'b0;
                    end else if (HOLD_COUNT == alarm_hold_pkg::COUNT_ZERO)
                    begin
                        state_next = alarm_hold_pkg::ST_ALARM;
                        rec_cnt_next = alarm_hold_pkg::COUNT_ZERO;
                        value_next = alarm_hold_pkg::ALARM_CODE;
                        no_value_next = 1'b0;
                    end else begin
                        state_next = alarm_hold_pkg::ST_HOLD;
                        hold_cnt_next = alarm_hold_pkg::COUNT_ONE;
                        no_value_next = !have_value_reg;
                    end
                end
                alarm_hold_pkg::ST_HOLD: begin
                    if (sample_valid) begin
                        state_next = alarm_hold_pkg::ST_NORMAL;
                        value_next = corrected;
                        no_value_next = 1'b0;
                    end else if (HOLD_COUNT == alarm_hold_pkg::HOLD_FOREVER)
                    begin
                        state_next = alarm_hold_pkg::ST_HOLD;
                    end else if (hold_cnt_reg >= HOLD_COUNT) begin
                        state_next = alarm_hold_pkg::ST_ALARM;
                        rec_cnt_next = alarm_hold_pkg::COUNT_ZERO;
                        value_next = alarm_hold_pkg::ALARM_CODE;
                        no_value_next = 1'b0;
                    end else begin
                        hold_cnt_next = hold_cnt_reg
                            + alarm_hold_pkg::COUNT_ONE;
                    end
                end
                alarm_hold_pkg::ST_ALARM: begin
                    if (!sample_valid) begin
                        rec_cnt_next = alarm_hold_pkg::COUNT_ZERO;
                    end else if (rec_cnt_reg + alarm_hold_pkg::COUNT_ONE
                        >= RECOVERY_COUNT) begin
                        state_next = alarm_hold_pkg::ST_NORMAL;
                        rec_cnt_next = alarm_hold_pkg::COUNT_ZERO;
                        value_next = corrected;
                    end else begin
                        rec_cnt_next = rec_cnt_reg
                            + alarm_hold_pkg::COUNT_ONE;
                    end
                end
                default: begin
                    state_next = alarm_hold_pkg::ST_NORMAL;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= alarm_hold_pkg::ST_NORMAL;
            hold_cnt_reg <= alarm_hold_pkg::COUNT_ZERO;
            rec_cnt_reg <= alarm_hold_pkg::COUNT_ZERO;
        end else begin
            state_reg <= state_next;
            hold_cnt_reg <= hold_cnt_next;
            rec_cnt_reg <= rec_cnt_next;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            value_reg <= alarm_hold_pkg::OUT_RESET;
            no_value_reg <= 1'b1;
            have_value_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            value_reg <= value_next;
            no_value_reg <= no_value_next;
            strobe_reg <= SAMPLE_STROBE;
            if (SAMPLE_STROBE && sample_valid) begin
                have_value_reg <= 1'b1;
            end
        end
    end

    // Indicators follow the head one clock later and are never held.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            HEAD_STATUS_OUT <= 1'b0;
            LASER_EMIT_OUT <= 1'b0;
            SPECULAR_ACTIVE <= 1'b0;
        end else begin
            HEAD_STATUS_OUT <= HEAD_STATUS_IN;
            LASER_EMIT_OUT <= LASER_EMIT_IN;
            SPECULAR_ACTIVE <= specular;
        end
    end

    assign OUT_VALUE = value_reg;
    assign OUT_STROBE = strobe_reg;
    assign OUT_NO_VALUE = no_value_reg;
    assign ALARM = (state_reg == alarm_hold_pkg::ST_ALARM);
    assign HOLDING = (state_reg == alarm_hold_pkg::ST_HOLD);

    // Calibration checks the head's routing and inputs at start and while collecting.
    assign group_input = CAL_COND.laser_group_select
        ? CAL_COND.laser_group_two_input : CAL_COND.laser_group_one_input;
    assign cal_blocked = !CAL_COND.assigned_to_output
        || (CAL_COND.interference_suppression_on
        && CAL_COND.interference_group
        == alarm_hold_pkg::GROUP_THIRD)
        || !CAL_COND.remote_input || !group_input;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cal_reg <= alarm_hold_pkg::CAL_IDLE;
            cal_done_reg <= 1'b0;
        end else begin
            case (cal_reg)
                alarm_hold_pkg::CAL_IDLE: begin
                    if (CAL_START) begin
                        cal_done_reg <= 1'b0;
                        if (cal_blocked) begin
                            cal_reg <= alarm_hold_pkg::CAL_FAILED;
                        end else begin
                            cal_reg <= alarm_hold_pkg::CAL_COLLECT;
                        end
                    end
                end
                alarm_hold_pkg::CAL_COLLECT: begin
                    if (cal_blocked) begin
                        cal_reg <= alarm_hold_pkg::CAL_FAILED;
                    end else if (CAL_STOP) begin
                        cal_reg <= alarm_hold_pkg::CAL_IDLE;
                        cal_done_reg <= 1'b1;
                    end
                end
                alarm_hold_pkg::CAL_FAILED: begin
                    if (CAL_START && !cal_blocked) begin
                        cal_reg <= alarm_hold_pkg::CAL_COLLECT;
                    end
                end
                default: begin
                    cal_reg <= alarm_hold_pkg::CAL_IDLE;
                end
            endcase
        end
    end

    // Light levels seen while collecting; samples outside 1 to 99 clamp.
    always_comb begin
        if (SAMPLE.light_level < alarm_hold_pkg::LIGHT_MIN) begin
            req_level = alarm_hold_pkg::LIGHT_MIN;
        end else if (SAMPLE.light_level > alarm_hold_pkg::LIGHT_MAX) begin
            req_level = alarm_hold_pkg::LIGHT_MAX;
        end else begin
            req_level = SAMPLE.light_level;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            max_reg <= alarm_hold_pkg::LIGHT_MIN;
            min_reg <= alarm_hold_pkg::LIGHT_MAX;
            seen_reg <= 1'b0;
        end else if (cal_reg != alarm_hold_pkg::CAL_COLLECT) begin
            max_reg <= alarm_hold_pkg::LIGHT_MIN;
            min_reg <= alarm_hold_pkg::LIGHT_MAX;
            seen_reg <= 1'b0;
        end else if (SAMPLE_STROBE) begin
            seen_reg <= 1'b1;
            if (req_level > max_reg) begin
                max_reg <= req_level;
            end
            if (req_level < min_reg) begin
                min_reg <= req_level;
            end
        end
    end

    // Mode and limits: host writes, overridden by a finished calibration.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            auto_reg <= 1'b1;
            hi_reg <= alarm_hold_pkg::HI_RESET;
            lo_reg <= alarm_hold_pkg::LO_RESET;
        end else if (cal_reg == alarm_hold_pkg::CAL_COLLECT && CAL_STOP
            && !cal_blocked) begin
            auto_reg <= 1'b0;
            if (seen_reg) begin
                hi_reg <= max_reg;
                lo_reg <= min_reg;
            end
        end else if (ADJUST_WRITE) begin
            auto_reg <= ADJUST_AUTO;
            hi_reg <= (ADJUST_HI > alarm_hold_pkg::LIGHT_MAX)
                ? alarm_hold_pkg::LIGHT_MAX : ((ADJUST_HI
                < alarm_hold_pkg::LIGHT_MIN) ? alarm_hold_pkg::LIGHT_MIN
                : ADJUST_HI);
            lo_reg <= (ADJUST_LO > alarm_hold_pkg::LIGHT_MAX)
                ? alarm_hold_pkg::LIGHT_MAX : ((ADJUST_LO
                < alarm_hold_pkg::LIGHT_MIN) ? alarm_hold_pkg::LIGHT_MIN
                : ADJUST_LO);
        end
    end

    // The light level command stays inside the limits in manual mode.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cmd_reg <= alarm_hold_pkg::LIGHT_MIN;
        end else if (auto_reg) begin
            cmd_reg <= req_level;
        end else if (req_level > hi_reg) begin
            cmd_reg <= hi_reg;
        end else if (req_level < lo_reg) begin
            cmd_reg <= lo_reg;
        end else begin
            cmd_reg <= req_level;
        end
    end

    assign AUTO_LIGHT_LEVEL_ADJUST = auto_reg;
    assign LIMIT_HI = hi_reg;
    assign LIMIT_LO = lo_reg;
    assign LIGHT_LEVEL_CMD = cmd_reg;
    assign CAL_BUSY = (cal_reg == alarm_hold_pkg::CAL_COLLECT);
    assign CAL_FAIL = (cal_reg == alarm_hold_pkg::CAL_FAILED);
    assign CAL_DONE = cal_done_reg;

endmodule : measurement_alarm_hold

// ### hdl/alarm_hold_pkg.sv
package alarm_hold_pkg;

    localparam int VALUE_W = 24;
    localparam int OUT_W = 32;
    localparam int COUNT_W = 14;
    localparam int LEVEL_W = 4;
    localparam int LIGHT_W = 7;

    // Hold count at which the last value is kept forever.
    localparam logic [COUNT_W-1:0] HOLD_FOREVER = 14'h270F;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX = 4'h9;

    // Output code for alarm, the value -FFFFFF in two's complement.
    localparam logic [OUT_W-1:0] ALARM_CODE = 32'hFF00_0001;
    localparam logic [OUT_W-1:0] OUT_RESET = 32'h0000_0000;

    // Specular correction: value times SPEC_NUM, shifted right SPEC_SHIFT.
    localparam logic [8:0] SPEC_NUM = 9'h0B5;
    localparam int SPEC_SHIFT = 8;

    // Light adjustment limits, 1 to 99.
    localparam logic [LIGHT_W-1:0] LIGHT_MIN = 7'h01;
    localparam logic [LIGHT_W-1:0] LIGHT_MAX = 7'h63;
    localparam logic [LIGHT_W-1:0] HI_RESET = 7'h63;
    localparam logic [LIGHT_W-1:0] LO_RESET = 7'h01;

    // Interference prevention group code of the third group.
    localparam logic [1:0] GROUP_THIRD = 2'h2;

    localparam logic [COUNT_W-1:0] COUNT_ZERO = 14'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 14'h0001;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_HOLD = 3'b010,
        ST_ALARM = 3'b100
    } hold_state_e;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_COLLECT = 3'b010,
        CAL_FAILED = 3'b100
    } cal_state_e;

    typedef struct packed {
        logic signed [VALUE_W-1:0] value;
        logic in_range;
        logic light_excess;
        logic light_short;
        logic [LEVEL_W-1:0] light_status;
        logic [LIGHT_W-1:0] light_level;
    } sample_s;

    typedef struct packed {
        logic assigned_to_output;
        logic interference_suppression_on;
        logic [1:0] interference_group;
        logic remote_input;
        logic laser_group_select;
        logic laser_group_one_input;
        logic laser_group_two_input;
    } cal_cond_s;

endpackage : alarm_hold_pkg

// ### dv/sensor_head_model.sv
`timescale 1ns/1ps
// Sensor head: kind 0 valid, 1 out of range, 2 light excess, 3 light short,
// 4 weak peak with a received-light status of 2.
module sensor_head_model (
    input wire logic go,
    input wire logic [2:0] kind,
    input wire logic [23:0] val,
    input wire logic [6:0] light,
    output logic strobe,
    output alarm_hold_pkg::sample_s smp
);
    always_comb begin
        strobe = go;
        // Between samples the value is not valid, so it shows a new pattern.
        smp.value = go ? val : ~val;
        smp.in_range = kind != 3'h1;
        smp.light_excess = kind == 3'h2;
        smp.light_short = kind == 3'h3;
        smp.light_status = (kind == 3'h4) ? 4'h2 : 4'h9;
        smp.light_level = light;
    end
endmodule : sensor_head_model

// ### dv/measurement_alarm_hold_monitor.sv
`timescale 1ns/1ps
module measurement_alarm_hold_monitor (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SAMPLE_STROBE,
    input wire alarm_hold_pkg::sample_s SAMPLE,
    input wire logic [alarm_hold_pkg::COUNT_W-1:0] HOLD_COUNT,
    input wire logic [alarm_hold_pkg::COUNT_W-1:0] RECOVERY_COUNT,
    input wire logic [alarm_hold_pkg::LEVEL_W-1:0] THRESHOLD_LEVEL,
    input wire logic HEAD_TRANSPARENT_TYPE,
    input wire logic HEAD_STATUS_IN,
    input wire logic LASER_EMIT_IN,
    input wire logic CAL_START,
    input wire logic CAL_STOP,
    input wire alarm_hold_pkg::cal_cond_s CAL_COND,
    input wire logic [alarm_hold_pkg::OUT_W-1:0] OUT_VALUE,
    input wire logic OUT_STROBE,
    input wire logic ALARM,
    input wire logic HOLDING,
    input wire logic HEAD_STATUS_OUT,
    input wire logic LASER_EMIT_OUT,
    input wire logic SPECULAR_ACTIVE,
    input wire logic AUTO_LIGHT_LEVEL_ADJUST,
    input wire logic CAL_BUSY,
    input wire logic CAL_DONE,
    input wire logic CAL_FAIL
);
    logic bad;
    logic ok;
    assign bad = !SAMPLE.in_range || SAMPLE.light_excess ||
        SAMPLE.light_short || (SAMPLE.light_status < THRESHOLD_LEVEL);
    assign ok = CAL_COND.assigned_to_output && CAL_COND.remote_input &&
        !(CAL_COND.interference_suppression_on &&
        CAL_COND.interference_group == alarm_hold_pkg::GROUP_THIRD) &&
        (CAL_COND.laser_group_select ? CAL_COND.laser_group_two_input :
        CAL_COND.laser_group_one_input);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_strobe; SAMPLE_STROBE |=> OUT_STROBE; endproperty
    a_strobe: assert property (p_strobe) else $error("no strobe");
    property p_idle;
        !SAMPLE_STROBE |=> !OUT_STROBE && $stable(ALARM) &&
            $stable(HOLDING) && $stable(OUT_VALUE);
    endproperty
    a_idle: assert property (p_idle) else $error("moved idle");
    property p_code; ALARM |-> OUT_VALUE == alarm_hold_pkg::ALARM_CODE;
    endproperty
    a_code: assert property (p_code) else $error("alarm code");
    property p_hold;
        SAMPLE_STROBE && bad && !ALARM && !HOLDING &&
            HOLD_COUNT != alarm_hold_pkg::COUNT_ZERO |=>
            HOLDING && $stable(OUT_VALUE);
    endproperty
    a_hold: assert property (p_hold) else $error("no hold");
    property p_zero;
        SAMPLE_STROBE && bad && HOLD_COUNT == alarm_hold_pkg::COUNT_ZERO
            |=> ALARM;
    endproperty
    a_zero: assert property (p_zero) else $error("no alarm");
    property p_forever;
        SAMPLE_STROBE && !ALARM &&
            HOLD_COUNT == alarm_hold_pkg::HOLD_FOREVER |=> !ALARM;
    endproperty
    a_forever: assert property (p_forever) else $error("alarm");
    property p_recover;
        SAMPLE_STROBE && ALARM && !bad &&
            RECOVERY_COUNT <= alarm_hold_pkg::COUNT_ONE |=> !ALARM;
    endproperty
    a_recover: assert property (p_recover) else $error("stuck");
    property p_live;
        1 |=> HEAD_STATUS_OUT == $past(HEAD_STATUS_IN) &&
            LASER_EMIT_OUT == $past(LASER_EMIT_IN);
    endproperty
    a_live: assert property (p_live) else $error("indicator");
    property p_transp; HEAD_TRANSPARENT_TYPE [*2] |-> SPECULAR_ACTIVE;
    endproperty
    a_transp: assert property (p_transp) else $error("mount");
    property p_cal_go; CAL_START && !CAL_BUSY && ok |=> CAL_BUSY && !CAL_FAIL;
    endproperty
    a_cal_go: assert property (p_cal_go) else $error("start");
    property p_cal_bad;
        CAL_START && !CAL_BUSY && !ok |=> CAL_FAIL && !CAL_BUSY;
    endproperty
    a_cal_bad: assert property (p_cal_bad)
        else $error("fail");
    property p_cal_drop; CAL_BUSY && !CAL_STOP && !ok |=> CAL_FAIL;
    endproperty
    a_cal_drop: assert property (p_cal_drop) else $error("drop");
    property p_cal_end;
        CAL_STOP && CAL_BUSY && ok |=> CAL_DONE && !CAL_BUSY &&
            !AUTO_LIGHT_LEVEL_ADJUST;
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("stop");
    c_alarm: cover property ($rose(ALARM));
    c_hold: cover property ($rose(HOLDING));
    c_done: cover property ($rose(CAL_DONE));
endmodule : measurement_alarm_hold_monitor

bind measurement_alarm_hold measurement_alarm_hold_monitor mon (
    .CLK(CLK), .RST(RST), .SAMPLE_STROBE(SAMPLE_STROBE), .SAMPLE(SAMPLE),
    .HOLD_COUNT(HOLD_COUNT), .RECOVERY_COUNT(RECOVERY_COUNT),
    .THRESHOLD_LEVEL(THRESHOLD_LEVEL),
    .HEAD_TRANSPARENT_TYPE(HEAD_TRANSPARENT_TYPE),
    .HEAD_STATUS_IN(HEAD_STATUS_IN), .LASER_EMIT_IN(LASER_EMIT_IN),
    .CAL_START(CAL_START), .CAL_STOP(CAL_STOP), .CAL_COND(CAL_COND),
    .OUT_VALUE(OUT_VALUE), .OUT_STROBE(OUT_STROBE), .ALARM(ALARM),
    .HOLDING(HOLDING), .HEAD_STATUS_OUT(HEAD_STATUS_OUT),
    .LASER_EMIT_OUT(LASER_EMIT_OUT), .SPECULAR_ACTIVE(SPECULAR_ACTIVE),
    .AUTO_LIGHT_LEVEL_ADJUST(AUTO_LIGHT_LEVEL_ADJUST), .CAL_BUSY(CAL_BUSY),
    .CAL_DONE(CAL_DONE), .CAL_FAIL(CAL_FAIL)
);

// ### dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
    begin compares++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value at %0t: %s", $time, msg); end end
module tb_top;
    logic clk = 1'b0, rst, go, spec, transp, hs_in, le_in;
    logic adj_wr, adj_auto, cal_start, cal_stop, strobe;
    logic out_strobe, no_value, alarm, holding, hs_out, le_out;
    logic spec_act, auto_adj, cal_busy, cal_done, cal_fail;
    logic [2:0] kind;
    logic [23:0] val;
    logic [6:0] light, adj_hi, adj_lo, lim_hi, lim_lo, lvl_cmd;
    logic [13:0] hold_cnt, rec_cnt;
    logic [3:0] thr;
    logic [31:0] out_value;
    logic signed [31:0] e;
    alarm_hold_pkg::cal_cond_s cond, good_c;
    alarm_hold_pkg::sample_s smp;
    int fails = 0, compares = 0;
    always #12.5 clk = ~clk;
    sensor_head_model head (.go(go), .kind(kind), .val(val), .light(light),
        .strobe(strobe), .smp(smp));
    measurement_alarm_hold dut (.CLK(clk), .RST(rst), .SAMPLE_STROBE(strobe),
        .SAMPLE(smp), .HOLD_COUNT(hold_cnt), .RECOVERY_COUNT(rec_cnt),
        .THRESHOLD_LEVEL(thr), .MOUNT_SPECULAR(spec),
        .HEAD_TRANSPARENT_TYPE(transp), .HEAD_STATUS_IN(hs_in),
        .LASER_EMIT_IN(le_in), .ADJUST_WRITE(adj_wr), .ADJUST_AUTO(adj_auto),
        .ADJUST_HI(adj_hi), .ADJUST_LO(adj_lo), .CAL_START(cal_start),
        .CAL_STOP(cal_stop), .CAL_COND(cond), .OUT_VALUE(out_value),
        .OUT_STROBE(out_strobe), .OUT_NO_VALUE(no_value), .ALARM(alarm),
        .HOLDING(holding), .HEAD_STATUS_OUT(hs_out), .LASER_EMIT_OUT(le_out),
        .SPECULAR_ACTIVE(spec_act), .AUTO_LIGHT_LEVEL_ADJUST(auto_adj),
        .LIMIT_HI(lim_hi), .LIMIT_LO(lim_lo), .LIGHT_LEVEL_CMD(lvl_cmd),
        .CAL_BUSY(cal_busy), .CAL_DONE(cal_done), .CAL_FAIL(cal_fail));

    function automatic logic [31:0] sx(input logic [23:0] v);
        return {{8{v[23]}}, v};
    endfunction : sx

    // Called at a falling edge; returns at the next one, strobe still high.
    task automatic step(input logic [2:0] k, input logic [23:0] v);
        go = 1'b1;
        kind = k;
        val = v;
        @(negedge clk);
        `CHK(out_strobe, 1'b1, "out strobe")
    endtask : step

    task automatic idle;
        go = 1'b0;
        @(negedge clk);
    endtask : idle

    task automatic t_hold;
        hold_cnt = 14'h0002;
        step(3'h1, 24'h00_0010);
        `CHK(no_value, 1'b1, "no value mark")
        step(3'h0, 24'h00_0ABC);
        `CHK(no_value, 1'b0, "value seen")
        step(3'h1, 24'h00_0011);
        `CHK(holding, 1'b1, "holding")
        step(3'h2, 24'h00_0012);
        `CHK(out_value, sx(24'h00_0ABC), "held value")
        step(3'h3, 24'h00_0013);
        `CHK(alarm, 1'b1, "alarm after count")
        `CHK(out_value, alarm_hold_pkg::ALARM_CODE, "code")
        step(3'h0, 24'h00_0100);
        step(3'h4, 24'h00_0101);
        step(3'h0, 24'h00_0102);
        `CHK(holding, 1'b0, "hold release")
        `CHK(out_value, sx(24'h00_0102), "release value")
    endtask : t_hold

    task automatic t_kinds;
        hold_cnt = 14'h0000;
        for (int i = 1; i < 5; i++) begin
            step(3'(i), 24'h00_0020);
            `CHK(alarm, 1'b1, "impossible kind")
            step(3'h0, 24'h00_0021);
            `CHK(alarm, 1'b0, "zero recovery")
        end
        thr = 4'h0;
        step(3'h4, 24'h00_0022);
        `CHK(alarm, 1'b0, "level zero")
        thr = alarm_hold_pkg::LEVEL_MAX;
        step(3'h0, 24'h00_0023);
        `CHK(alarm, 1'b0, "level nine edge")
        thr = 4'h5;
    endtask : t_kinds

    task automatic t_recover;
        rec_cnt = 14'h0003;
        for (int i = 0; i < 7; i++) begin
            step((i == 0 || i == 3) ? 3'h1 : 3'h0, 24'h00_0077);
            `CHK(alarm, i < 6, "recovery count")
        end
        `CHK(out_value, sx(24'h00_0077), "recovered")
    endtask : t_recover

    task automatic t_forever;
        hold_cnt = alarm_hold_pkg::HOLD_FOREVER;
        for (int i = 0; i < 12; i++) begin
            step(3'h1, 24'h00_0030);
        end
        `CHK(alarm, 1'b0, "never alarm")
        `CHK(out_value, sx(24'h00_0077), "kept")
        go = 1'b0;
        hs_in = 1'b1;
        le_in = 1'b1;
        @(negedge clk);
        `CHK({hs_out, le_out, holding}, 3'b111, "live status")
        step(3'h0, 24'h00_0031);
        hold_cnt = 14'h0000;
        rec_cnt = 14'h0000;
    endtask : t_forever

    task automatic t_mount;
        spec = 1'b1;
        idle();
        step(3'h0, 24'hFF_F000);
        e = $signed(sx(24'hFF_F000))
            * $signed({23'h00_0000, alarm_hold_pkg::SPEC_NUM});
        e = e >>> alarm_hold_pkg::SPEC_SHIFT;
        `CHK(out_value, e, "specular value")
        spec = 1'b0;
        transp = 1'b1;
        idle();
        idle();
        `CHK(spec_act, 1'b1, "forced specular")
        transp = 1'b0;
    endtask : t_mount

    task automatic t_cal;
        adj_auto = 1'b1;
        adj_hi = 7'h7F;
        adj_lo = 7'h00;
        adj_wr = 1'b1;
        light = 7'h00;
        @(negedge clk);
        adj_wr = 1'b0;
        `CHK({lim_hi, lim_lo}, {7'h63, 7'h01}, "clamped limits")
        `CHK(lvl_cmd, alarm_hold_pkg::LIGHT_MIN, "level floor")
        for (int i = 0; i < 5; i++) begin
            cond = good_c;
            cond.assigned_to_output = i != 0;
            cond.interference_suppression_on = i == 1;
            cond.interference_group = (i == 1) ? 2'h2 : 2'h0;
            cond.remote_input = i != 2;
            cond.laser_group_select = i == 3;
            cal_start = 1'b1;
            @(negedge clk);
            cal_start = 1'b0;
            `CHK(cal_fail, i < 4, "start fail")
            `CHK(cal_busy, i == 4, "start busy")
            @(negedge clk);
        end
        cond.remote_input = 1'b0;
        @(negedge clk);
        `CHK(cal_fail, 1'b1, "remote dropped")
        cond = good_c;
        cal_start = 1'b1;
        @(negedge clk);
        cal_start = 1'b0;
        light = 7'h1E;
        step(3'h0, 24'h00_0040);
        light = 7'h46;
        step(3'h0, 24'h00_0041);
        light = 7'h05;
        step(3'h0, 24'h00_0042);
        go = 1'b0;
        cal_stop = 1'b1;
        @(negedge clk);
        cal_stop = 1'b0;
        `CHK({cal_done, cal_busy}, 2'b10, "cal end")
        `CHK(auto_adj, 1'b0, "manual mode")
        `CHK({lim_hi, lim_lo}, {7'h46, 7'h05}, "cal limits")
        light = 7'h5A;
        idle();
        `CHK(lvl_cmd, 7'h46, "manual ceiling")
    endtask : t_cal

    task automatic wrap_up;
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        good_c = '{1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0};
        cond = good_c;
        {rst, go, spec, transp, hs_in, le_in} = 6'b100000;
        {adj_wr, adj_auto, cal_start, cal_stop} = 4'h0;
        {kind, val, light, adj_hi, adj_lo} = '0;
        {hold_cnt, rec_cnt, thr} = {14'h0000, 14'h0000, 4'h5};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_hold();
        t_kinds();
        t_recover();
        t_forever();
        t_mount();
        t_cal();
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule : tb_top
